/* rtl/timer_pkg.sv */
// constants, field layouts and state types for the 16-bit multimode timer
// assumes a 25 MHz APB clock and byte-wide registers in the low bits of each word
// =====================================================================
package timer_pkg;

    // =================================================================
    // register map (byte addresses)
    localparam logic [7:0]  ADDR_COUNT_HI   = 8'h00;
    localparam logic [7:0]  ADDR_COUNT_LO   = 8'h04;
    localparam logic [7:0]  ADDR_RELOAD_HI  = 8'h08;
    localparam logic [7:0]  ADDR_RELOAD_LO  = 8'h0C;
    localparam logic [7:0]  ADDR_PWM_HI     = 8'h10;
    localparam logic [7:0]  ADDR_PWM_LO     = 8'h14;
    localparam logic [7:0]  ADDR_CONTROL    = 8'h18;
    localparam logic [7:0]  ADDR_CTRL_ZERO  = 8'h1C;
    localparam logic [7:0]  ADDR_CAPTURE_HI = 8'h20;
    localparam logic [7:0]  ADDR_CAPTURE_LO = 8'h24;

    // =================================================================
    // control register fields
    localparam int          CTL_EN_BIT      = 7;
    localparam int          CTL_POL_BIT     = 6;
    localparam int          CTL_PRE_HI      = 5;
    localparam int          CTL_PRE_LO      = 3;
    localparam int          CTL_MODE_HI     = 2;
    localparam int          CTL_MODE_LO     = 0;
    localparam int          ISEL_HI         = 6;
    localparam int          ISEL_LO         = 5;

    // =================================================================
    // values
    localparam logic [15:0] COUNT_RESTART   = 16'h0001;
    localparam logic [15:0] RELOAD_RESET    = 16'hFFFF;
    localparam logic [15:0] WORD_ZERO       = 16'h0000;
    localparam logic [7:0]  BYTE_ZERO       = 8'h00;
    localparam logic [6:0]  PSC_ZERO        = 7'h00;
    localparam logic [7:0]  PSC_ONE         = 8'h01;

    typedef enum logic [2:0] {
        MODE_ONE_SHOT   = 3'b000,
        MODE_CONTINUOUS = 3'b001,
        MODE_PWM_SINGLE = 3'b011,
        MODE_CAPT_CMP   = 3'b110,
        MODE_COMP_COUNT = 3'b111
    } timer_mode_t;

    typedef enum logic [1:0] {
        ISEL_BOTH    = 2'b00,
        ISEL_CAPTURE = 2'b01,
        ISEL_RELOAD  = 2'b10,
        ISEL_BOTH_B  = 2'b11
    } isel_t;

    typedef enum logic [1:0] {
        ST_OFF       = 2'b00,
        ST_WAIT_EDGE = 2'b01,
        ST_RUN       = 2'b10
    } run_state_t;

endpackage

/* rtl/pin_edge_sync.sv */
// two-flop synchroniser with edge detection for one asynchronous input
// assumes the input may change at any time relative to pclk
`timescale 1ns/100ps
module pin_edge_sync
    import timer_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pin_in,
    output logic      level,
    output logic      rise,
    output logic      fall
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } sync_state_t;

    sync_state_t st_r;
    sync_state_t st_nxt;

    always_comb
    begin
        st_nxt    = st_r;
        st_nxt.s1 = pin_in;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    // first stage feeds only the second
    assign level = st_r.s2;
    assign rise  = st_r.s2 & ~st_r.s3;
    assign fall  = ~st_r.s2 & st_r.s3;

endmodule

/* rtl/multimode_timer.sv */
// 16-bit multimode timer with APB register access
// assumes an APB master on pclk; timer pin and comparator are asynchronous
// pin and comparator edges reach the counter about three clocks late
`timescale 1ns/100ps
module multimode_timer
    import timer_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        timer_in,
    input  wire logic        timer_in_af_en,
    input  wire logic        comp_out,
    output logic             timer_out,
    output logic             timer_irq
);

    // whole block state: one register, one next-state copy
    typedef struct packed {
        logic [15:0] cnt;
        logic [15:0] rld;
        logic [15:0] pwm;
        logic [15:0] cap;
        logic [7:0]  hold;
        logic        en;
        logic        pol;
        logic [2:0]  pre;
        logic [2:0]  mode;
        logic [1:0]  isel;
        logic [6:0]  psc;
        logic        out;
        logic        irq;
        run_state_t  run;
        logic [31:0] rdata;
    } timer_state_t;

    timer_state_t st_r;
    timer_state_t st_nxt;

    // =================================================================
    // input synchronisers
    logic tin_rise;
    logic tin_fall;
    logic cmp_rise;
    logic cmp_fall;

    pin_edge_sync u_tin_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pin_in  (timer_in),
        .level   (),
        .rise    (tin_rise),
        .fall    (tin_fall)
    );

    pin_edge_sync u_cmp_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pin_in  (comp_out),
        .level   (),
        .rise    (cmp_rise),
        .fall    (cmp_fall)
    );

    // =================================================================
    // bus decode
    logic bus_setup;
    logic bus_access;
    logic addr_hit;
    logic wr_en;
    logic rd_en;

    always_comb
    begin
        case (paddr)
            ADDR_COUNT_HI,
            ADDR_COUNT_LO,
            ADDR_RELOAD_HI,
            ADDR_RELOAD_LO,
            ADDR_PWM_HI,
            ADDR_PWM_LO,
            ADDR_CONTROL,
            ADDR_CTRL_ZERO,
            ADDR_CAPTURE_HI,
            ADDR_CAPTURE_LO:
                addr_hit = 1'b1;
            default:
                addr_hit = 1'b0;
        endcase
    end

    assign bus_setup  = psel & ~penable;
    assign bus_access = psel & penable;
    assign wr_en      = bus_access & pwrite & addr_hit;
    // read strobe in the setup cycle, the edge at which read data is sampled
    assign rd_en      = bus_setup & ~pwrite & addr_hit;
    // zero wait states; unmapped addresses answer with an error
    assign pready     = 1'b1;
    assign pslverr    = bus_access & ~addr_hit;

    // =================================================================
    // timer datapath
    logic [7:0]  psc_lim;
    logic        tick;
    logic        edge_sel;
    logic        tin_edge;
    logic        step;
    logic        at_reload;
    logic        cap_irq_ok;
    logic        rld_irq_ok;
    logic [15:0] cnt_inc;

    always_comb
    begin
        // divide by two to the power of the prescale field
        psc_lim    = (PSC_ONE << st_r.pre) - PSC_ONE;
        tick       = st_r.en & (st_r.psc == psc_lim[6:0]);
        // the polarity bit doubles as edge select: 0 rising, 1 falling
        edge_sel   = st_r.pol ? cmp_fall : cmp_rise;
        tin_edge   = timer_in_af_en & (st_r.pol ? tin_fall : tin_rise);
        // the source select only narrows interrupts in capture/compare mode
        cap_irq_ok = (st_r.isel != ISEL_RELOAD);
        rld_irq_ok = (st_r.isel != ISEL_CAPTURE) || (st_r.mode != MODE_CAPT_CMP);
        // compared before the step, so the reload value itself is counted
        at_reload  = (st_r.cnt == st_r.rld);
        cnt_inc    = st_r.cnt + COUNT_RESTART;
        case (st_r.mode)
            MODE_COMP_COUNT:
                step = st_r.en & edge_sel;
            MODE_CAPT_CMP:
                step = tick & (st_r.run == ST_RUN);
            default:
                step = tick;
        endcase
    end

    // =================================================================
    // next state
    always_comb
    begin
        st_nxt     = st_r;
        st_nxt.irq = 1'b0;

        // prescaler; cleared whenever the timer stops so restarts are aligned
        // also held while waiting for the start edge, so capture times are exact
        if (!st_r.en || tick || st_r.run == ST_WAIT_EDGE)
            st_nxt.psc = PSC_ZERO;
        else
            st_nxt.psc = st_r.psc + 7'h01;

        if (step)
        begin
            if (at_reload)
            begin
                // every later pass restarts from the fixed value
                st_nxt.cnt = COUNT_RESTART;
                st_nxt.out = ~st_r.out;
                st_nxt.irq = rld_irq_ok;
                // one-shot stops itself at reload; software re-enables it
                if (st_r.mode == MODE_ONE_SHOT)
                    st_nxt.en = 1'b0;
            end
            else
            begin
                st_nxt.cnt = cnt_inc;
                // match value below reload is the caller's duty
                if (st_r.mode == MODE_PWM_SINGLE && st_r.cnt == st_r.pwm)
                    st_nxt.out = ~st_r.out;
            end
        end

        // capture/compare sequencing
        if (st_r.mode == MODE_CAPT_CMP && st_r.en)
        begin
            case (st_r.run)
                ST_WAIT_EDGE:
                begin
                    // first edge only starts the count, no interrupt
                    if (tin_edge)
                        st_nxt.run = ST_RUN;
                end
                ST_RUN:
                begin
                    if (tin_edge)
                    begin
                        st_nxt.cap = st_r.cnt;
                        st_nxt.irq = st_nxt.irq | cap_irq_ok;
                    end
                end
                ST_OFF:
                    st_nxt.run = ST_WAIT_EDGE;
                default:
                    st_nxt.run = ST_OFF;
            endcase
        end
        else
        begin
            st_nxt.run = ST_OFF;
        end

        // register writes
        if (wr_en)
        begin
            case (paddr)
                ADDR_COUNT_HI:
                    st_nxt.cnt[15:8] = pwdata[7:0];
                ADDR_COUNT_LO:
                    st_nxt.cnt[7:0] = pwdata[7:0];
                ADDR_RELOAD_HI:
                    st_nxt.rld[15:8] = pwdata[7:0];
                ADDR_RELOAD_LO:
                    st_nxt.rld[7:0] = pwdata[7:0];
                ADDR_PWM_HI:
                    st_nxt.pwm[15:8] = pwdata[7:0];
                ADDR_PWM_LO:
                    st_nxt.pwm[7:0] = pwdata[7:0];
                ADDR_CONTROL:
                begin
                    st_nxt.en   = pwdata[CTL_EN_BIT];
                    st_nxt.pol  = pwdata[CTL_POL_BIT];
                    st_nxt.pre  = pwdata[CTL_PRE_HI:CTL_PRE_LO];
                    st_nxt.mode = pwdata[CTL_MODE_HI:CTL_MODE_LO];
                    // initial output level follows the polarity bit at enable
                    if (pwdata[CTL_EN_BIT] && !st_r.en)
                        st_nxt.out = pwdata[CTL_POL_BIT];
                end
                ADDR_CTRL_ZERO:
                    st_nxt.isel = pwdata[ISEL_HI:ISEL_LO];
                // capture bytes are read-only; a write there changes nothing
                default:
                    st_nxt.isel = st_r.isel;
            endcase
        end

        // reads only touch the holding byte, never the counter
        // latched at the edge that samples the high byte, so the pair is one snapshot
        if (rd_en && paddr == ADDR_COUNT_HI && st_r.en)
            st_nxt.hold = st_r.cnt[7:0];

        // read data is captured in the setup phase and held through access
        if (bus_setup)
        begin
            st_nxt.rdata = 32'h0000_0000;
            case (paddr)
                ADDR_COUNT_HI:
                    st_nxt.rdata[7:0] = st_r.cnt[15:8];
                ADDR_COUNT_LO:
                    st_nxt.rdata[7:0] = st_r.en ? st_r.hold : st_r.cnt[7:0];
                ADDR_RELOAD_HI:
                    st_nxt.rdata[7:0] = st_r.rld[15:8];
                ADDR_RELOAD_LO:
                    st_nxt.rdata[7:0] = st_r.rld[7:0];
                ADDR_PWM_HI:
                    st_nxt.rdata[7:0] = st_r.pwm[15:8];
                ADDR_PWM_LO:
                    st_nxt.rdata[7:0] = st_r.pwm[7:0];
                ADDR_CONTROL:
                    st_nxt.rdata[7:0] = {st_r.en, st_r.pol, st_r.pre, st_r.mode};
                ADDR_CTRL_ZERO:
                    st_nxt.rdata[ISEL_HI:ISEL_LO] = st_r.isel;
                ADDR_CAPTURE_HI:
                    st_nxt.rdata[7:0] = st_r.cap[15:8];
                ADDR_CAPTURE_LO:
                    st_nxt.rdata[7:0] = st_r.cap[7:0];
                default:
                    st_nxt.rdata = 32'h0000_0000;
            endcase
        end
    end

    // =================================================================
    // state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r       <= '0;
            st_r.cnt   <= COUNT_RESTART;
            st_r.rld   <= RELOAD_RESET;
            st_r.mode  <= MODE_ONE_SHOT;
            st_r.isel  <= ISEL_BOTH;
            st_r.run   <= ST_OFF;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign prdata    = st_r.rdata;
    assign timer_out = st_r.out;
    assign timer_irq = st_r.irq;

endmodule

/* testbench/multimode_timer_assertions.sv */
// port-level checker for the multimode timer
// assumes it is bound to multimode_timer; tracks the control byte from APB writes
`timescale 1ns/100ps
module multimode_timer_checker
    import timer_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        timer_in,
    input wire logic        timer_in_af_en,
    input wire logic        comp_out,
    input wire logic        timer_out,
    input wire logic        timer_irq
);
    // =========================================================
    // helpers
    logic [7:0] ctl_r;
    logic       wr_ctl;
    logic       bad_addr;
    logic       acc;
    assign acc      = psel && penable;
    assign wr_ctl   = acc && pwrite && paddr == ADDR_CONTROL;
    assign bad_addr = paddr[1:0] != 2'b00 || paddr > ADDR_CAPTURE_LO;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            ctl_r <= BYTE_ZERO;
        else if (wr_ctl)
            ctl_r <= pwdata[7:0];
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_enable_write;
        wr_ctl && pwdata[CTL_EN_BIT] && !ctl_r[CTL_EN_BIT];
    endsequence
    sequence s_pwm_reload;
        ctl_r[CTL_EN_BIT] && ctl_r[2:0] == MODE_PWM_SINGLE && timer_irq;
    endsequence
    property p_enable_level;
        s_enable_write |=> timer_out == $past(pwdata[CTL_POL_BIT]);
    endproperty
    property p_pwm_reload;
        s_pwm_reload |-> timer_out == ctl_r[CTL_POL_BIT] && $past(timer_out) != timer_out;
    endproperty
    property p_irq_pulse;
        ctl_r[CTL_EN_BIT] && ctl_r[5:3] != 3'b000 && timer_irq |=> !timer_irq;
    endproperty
    property p_no_irq_off;
        !ctl_r[CTL_EN_BIT] && !$past(ctl_r[CTL_EN_BIT]) |-> !timer_irq;
    endproperty
    property p_ready;
        acc |-> pready;
    endproperty
    property p_slverr;
        acc |-> pslverr == bad_addr;
    endproperty
    property p_bad_read;
        acc && !pwrite && bad_addr |-> prdata == 32'h00000000;
    endproperty
    property p_upper;
        acc && !pwrite |-> prdata[31:8] == 24'h000000;
    endproperty
    a_enable_level: assert property (p_enable_level) else $error("level after enable wrong");
    a_pwm_reload: assert property (p_pwm_reload) else $error("pwm reload level wrong");
    a_irq_pulse: assert property (p_irq_pulse) else $error("irq longer than one cycle");
    a_no_irq_off: assert property (p_no_irq_off) else $error("irq while disabled");
    a_ready: assert property (p_ready) else $error("pready low");
    a_slverr: assert property (p_slverr) else $error("pslverr wrong");
    a_bad_read: assert property (p_bad_read) else $error("unmapped read not zero");
    a_upper: assert property (p_upper) else $error("upper read bits set");
endmodule
bind multimode_timer multimode_timer_checker multimode_timer_checker_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_in(timer_in), .timer_in_af_en(timer_in_af_en),
    .comp_out(comp_out), .timer_out(timer_out), .timer_irq(timer_irq));

/* testbench/pin_source_model.sv */
// model of the timer input pin and the comparator output
// assumes pclk from the bench; both lines are always driven
`timescale 1ns/100ps
module pin_source_model
(
    input  wire logic pclk,
    output logic      comp_out,
    output logic      timer_in
);
    initial
    begin
        comp_out = 1'b0;
        timer_in = 1'b0;
    end
    // =========================================================
    // each level held four clocks so the synchroniser sees it
    task pulse(input logic to_pin, input int n);
        repeat (n)
        begin
            @(posedge pclk);
            if (to_pin) timer_in <= 1'b1; else comp_out <= 1'b1;
            repeat (4) @(posedge pclk);
            if (to_pin) timer_in <= 1'b0; else comp_out <= 1'b0;
            repeat (4) @(posedge pclk);
        end
    endtask
endmodule

/* testbench/multimode_timer_tb.sv */
// self-checking bench for the multimode timer over APB
// assumes a zero-wait slave; pins come from pin_source_model
`timescale 1ns/100ps
module multimode_timer_tb
    import timer_pkg::*;
;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = BYTE_ZERO;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        err;
    logic        af_en = 1'b0;
    logic        comp_out;
    logic        timer_in;
    logic        timer_out;
    logic        timer_irq;
    logic [31:0] q1;
    logic [31:0] q2;
    int          fails = 0;
    int          checked = 0;
    int          irqs = 0;
    int          cycles = 0;
    int          n;
    int          hi;
    multimode_timer multimode_timer_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer_in(timer_in), .timer_in_af_en(af_en), .comp_out(comp_out),
        .timer_out(timer_out), .timer_irq(timer_irq));
    pin_source_model pin_source_model_i (.pclk(pclk), .comp_out(comp_out), .timer_in(timer_in));
    initial
    begin
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        cycles++;
        if (timer_irq === 1'b1) irqs++;
        if (cycles == 20000)
        begin
            fails++;
            give_verdict();
        end
    end
    // =========================================================
    // tasks
    task give_verdict();
        if (fails == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d, q1);
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, BYTE_ZERO, q2);
        check("prdata", q2, {24'h000000, e});
    endtask
    // disable, load count, match and reload, enable last
    task setup(input logic [7:0] c, input logic [15:0] s, input logic [15:0] p, input logic [15:0] r);
        wr(ADDR_CONTROL, c);
        wr(ADDR_COUNT_HI, s[15:8]);
        wr(ADDR_COUNT_LO, s[7:0]);
        wr(ADDR_PWM_HI, p[15:8]);
        wr(ADDR_PWM_LO, p[7:0]);
        wr(ADDR_RELOAD_HI, r[15:8]);
        wr(ADDR_RELOAD_LO, r[7:0]);
        wr(ADDR_CONTROL, c | 8'h80);
    endtask
    // =========================================================
    // tests
    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd(ADDR_COUNT_LO, 8'h01);
        rd(ADDR_RELOAD_HI, 8'hFF);
        rd(8'h28, 8'h00);
        check("pslverr", err, 1);
        setup(8'h07, 16'h00FE, WORD_ZERO, RELOAD_RESET);
        rd(ADDR_COUNT_HI, 8'h00);
        pin_source_model_i.pulse(1'b0, 3);
        rd(ADDR_COUNT_LO, 8'hFE);
        rd(ADDR_COUNT_HI, 8'h01);
        pin_source_model_i.pulse(1'b0, 2);
        wr(ADDR_CONTROL, 8'h07);
        rd(ADDR_COUNT_LO, 8'h03);
        setup(8'h47, 16'h0002, WORD_ZERO, 16'h0004);
        pin_source_model_i.pulse(1'b0, 5);
        wr(ADDR_CONTROL, 8'h47);
        rd(ADDR_COUNT_LO, 8'h03);
        setup(8'h00, COUNT_RESTART, WORD_ZERO, 16'h0003);
        repeat (4) @(posedge pclk);
        rd(ADDR_CONTROL, 8'h00);
        check("timer_out", timer_out, 1);
        for (int p = 0; p < 2; p++)
        begin
            setup({1'b0, p[0], 6'b001011}, COUNT_RESTART, 16'h0003, 16'h0005);
            n = 0;
            hi = 0;
            do
            begin
                @(posedge pclk);
                #1;
            end
            while (timer_irq !== 1'b1);
            do
            begin
                hi += (timer_out === 1'b1);
                @(posedge pclk);
                #1;
                n++;
            end
            while (timer_irq !== 1'b1);
            check("pwm period", n, 10);
            check("pwm high", hi, p ? 6 : 4);
        end
        // start 2, reload 5, prescale 2: first period (5 - 2 + 1) * 2 clocks
        setup(8'h0B, 16'h0002, 16'h0003, 16'h0005);
        n = 0;
        do
        begin
            @(posedge pclk);
            #1;
            n++;
        end
        while (timer_irq !== 1'b1);
        check("first pwm period", n, 8);
        wr(ADDR_CTRL_ZERO, 8'h20);
        setup(8'h06, COUNT_RESTART, WORD_ZERO, RELOAD_RESET);
        irqs = 0;
        pin_source_model_i.pulse(1'b1, 2);
        check("irq count", irqs, 0);
        af_en <= 1'b1;
        pin_source_model_i.pulse(1'b1, 2);
        check("irq count", irqs, 1);
        apb(1'b0, ADDR_CAPTURE_LO, BYTE_ZERO, q1);
        pin_source_model_i.pulse(1'b1, 1);
        apb(1'b0, ADDR_CAPTURE_LO, BYTE_ZERO, q2);
        // rise to rise: 8 clocks of pulse tail, 3 of the read, 1 before the next rise
        check("capture delta", (q2 - q1) & 32'h000000FF, 32'h0000000C);
        wr(ADDR_CONTROL, 8'h06);
        wr(ADDR_CTRL_ZERO, 8'h40);
        wr(ADDR_CONTROL, 8'h86);
        pin_source_model_i.pulse(1'b1, 3);
        check("irq count", irqs, 2);
        give_verdict();
    end
endmodule
